// File: hw/flash_area_decode.sv
// Decoder that sorts flash word addresses into boot, application and read-while-write areas.
`timescale 1ns/1ps
module flash_area_decode #(
	parameter int ADDR_W = 13,
	parameter int BOOT_MIN_WORDS = 256,
	parameter int NO_READ_WHILE_WRITE_AREA_WORDS = 2048
) (
	// Area classification channel.
	flash_area_if.decoder area
);
	import flash_guard_pkg::*;

	localparam logic [ADDR_W:0] FLASH_WORDS = (ADDR_W+1)'(1 << ADDR_W);
	localparam logic [ADDR_W:0] NO_READ_WHILE_WRITE_AREA_SIZE = (ADDR_W+1)'(NO_READ_WHILE_WRITE_AREA_WORDS);
	localparam logic [ADDR_W:0] NO_READ_WHILE_WRITE_AREA_START = FLASH_WORDS - NO_READ_WHILE_WRITE_AREA_SIZE;

	// The largest boot area must still fit inside the no-read-while-write area.
	if (BOOT_MIN_WORDS * 8 > NO_READ_WHILE_WRITE_AREA_WORDS || NO_READ_WHILE_WRITE_AREA_WORDS > (1 << ADDR_W)) begin : g_bad_sizes
		$error("flash_area_decode: boot or no_read_while_write_area size does not fit the flash");
	end

	// Boot area words; fuse value 3 gives the smallest area, 0 the largest.
	function automatic logic [ADDR_W:0] boot_words(input logic [1:0] fuses);
		boot_words = (ADDR_W+1)'(BOOT_MIN_WORDS) << (2'h3 - fuses);
	endfunction : boot_words

	logic [ADDR_W:0] bootStartWide;

	// Boundary between application and boot areas from the boot size fuses.
	assign bootStartWide = FLASH_WORDS - boot_words(area.bootSize);
	assign area.bootStart = bootStartWide[ADDR_W-1:0];
	assign area.pcInBoot = area.pcAddr >= area.bootStart;
	assign area.tgtInBoot = area.tgtAddr >= area.bootStart;
	// The read-while-write area is fixed and sits below the boot area.
	assign area.tgtInRww = {1'b0, area.tgtAddr} < NO_READ_WHILE_WRITE_AREA_START;
endmodule : flash_area_decode

// File: hw/flash_area_if.sv
// Interface carrying addresses and area classification between guard and decoder.
`timescale 1ns/1ps
interface flash_area_if #(parameter int ADDR_W = 13);
	logic [1:0] bootSize;
	logic [ADDR_W-1:0] pcAddr;
	logic [ADDR_W-1:0] tgtAddr;
	logic [ADDR_W-1:0] bootStart;
	logic pcInBoot;
	logic tgtInBoot;
	logic tgtInRww;
	modport decoder (input bootSize, pcAddr, tgtAddr,
		output bootStart, pcInBoot, tgtInBoot, tgtInRww);
	modport user (output bootSize, pcAddr, tgtAddr,
		input bootStart, pcInBoot, tgtInBoot, tgtInRww);
endinterface : flash_area_if

// File: hw/flash_guard_pkg.sv
// Package with register map, field positions, lock encodings and types for the flash guard.
package flash_guard_pkg;
	// Register byte offsets on the AHB-Lite bus.
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] CONFIG_OFFSET = 8'h08;
	// Control register field positions.
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_ERASE_BIT = 1;
	localparam int CTRL_WRITE_BIT = 2;
	localparam int CTRL_LOCKSET_BIT = 3;
	localparam int CTRL_REENABLE_BIT = 4;
	localparam int CTRL_RWW_BUSY_BIT = 6;
	// Status register field positions.
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_HALT_BIT = 1;
	localparam int STAT_PC_BOOT_BIT = 2;
	localparam int STAT_APP_LOCK_LSB = 4;
	localparam int STAT_BOOT_LOCK_LSB = 6;
	localparam int STAT_BOOT_SIZE_LSB = 8;
	localparam int STAT_BOOT_RST_BIT = 10;
	localparam int STAT_MEM_LOCK_LSB = 12;
	// Config register field position.
	localparam int CFG_VEC_BOOT_BIT = 0;
	// Lock data positions inside the store-operation data byte.
	localparam int LOCKDATA_APP_LSB = 2;
	localparam int LOCKDATA_BOOT_LSB = 4;
	// The five command patterns accepted in the low control bits.
	localparam logic [4:0] CMD_PAT_LOAD = 5'h01;
	localparam logic [4:0] CMD_PAT_ERASE = 5'h03;
	localparam logic [4:0] CMD_PAT_WRITE = 5'h05;
	localparam logic [4:0] CMD_PAT_LOCKSET = 5'h09;
	localparam logic [4:0] CMD_PAT_REENABLE = 5'h11;
	// Reset values.
	localparam logic [1:0] LOCK_RESET = 2'h3;
	localparam logic CONFIG_RESET = 1'b0;
	localparam int APP_RESET_ADDR = 0;
	// Lock field encodings, one means unprogrammed.
	localparam logic [1:0] LOCK_NONE = 2'h3;
	localparam logic [1:0] LOCK_NO_WRITE = 2'h2;
	localparam logic [1:0] LOCK_ALL = 2'h0;
	localparam logic [1:0] LOCK_NO_READ = 2'h1;
	// Cycles during which an armed command waits for its store operation.
	localparam int SPM_WINDOW_CYCLES = 4;

	typedef enum logic [2:0] {CMD_NONE, CMD_LOAD, CMD_ERASE, CMD_WRITE, CMD_LOCKSET,
		CMD_REENABLE} spm_cmd_t;
	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_PROGRAM} prog_state_t;

	// True when the lock field forbids store writes into its area.
	function automatic logic write_blocked(input logic [1:0] lock);
		write_blocked = (lock == LOCK_NO_WRITE) || (lock == LOCK_ALL);
	endfunction : write_blocked

	// True when the lock field forbids cross-area loads into its area.
	function automatic logic read_blocked(input logic [1:0] lock);
		read_blocked = (lock == LOCK_NO_READ) || (lock == LOCK_ALL);
	endfunction : read_blocked
endpackage : flash_guard_pkg

// File: hw/flash_self_program_guard.sv
// Self-programming guard: lock checks, read-while-write control and AHB-Lite registers.
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - Store operations executed from the application area are ignored entirely.
// - Erase or write starts only from boot area; any page may be targeted.
// - Application/boot boundary follows the boot size fuses.
// - Core halting depends on the programmed target address, not the fetch address.
// - Programming a read-while-write page keeps the core running.
// - Programming a no-read-while-write page stalls the core throughout.
// - Busy flag reads one while the read-while-write area is blocked.
// - Boot area always lies inside the no-read-while-write area.
// - Application lock field restricts store writes and boot-side loads.
// - Boot lock field restricts store writes and application-side loads.
// - Read-protected application with boot vectors suppresses interrupts there.
// - Read-protected boot area with application vectors suppresses interrupts there.
// - Boot locks programmed by software or programmer, cleared only by chip erase or reset.
// - General write lock does not stop store-operation flash programming.
// - General read/write lock does not restrict loads or stores.
// - Reset vector is zero when boot-reset fuse is one, else boot start.
// - The core cannot alter fuse values.
// - Busy flag sets on read-while-write programming; clears on re-enable or load.
// - Enable stays high until programming ends; re-enable refused meanwhile.
module flash_self_program_guard #(
	parameter int ADDR_W = 13,
	parameter int BOOT_MIN_WORDS = 256,
	parameter int NO_READ_WHILE_WRITE_AREA_WORDS = 2048
) (
	// Clock and synchronous active-low reset.
	input wire logic clock,
	input wire logic nrst,
	// AHB-Lite slave port.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Core requests.
	input wire logic [ADDR_W-1:0] pcAddr,
	input wire logic spmReq,
	input wire logic [ADDR_W-1:0] spmAddr,
	input wire logic [7:0] spmData,
	input wire logic lpmReq,
	input wire logic [ADDR_W-1:0] lpmAddr,
	// Fuses, read only to the core.
	input wire logic [1:0] bootSizeFuses,
	input wire logic bootResetFuse,
	input wire logic [1:0] memLockMode,
	// Serial or parallel programmer.
	input wire logic progLockWr,
	input wire logic [3:0] progLockData,
	input wire logic chipErase,
	// Flash array.
	input wire logic flashDone,
	output logic flashStart,
	output logic flashErase,
	output logic flashWrite,
	output logic [ADDR_W-1:0] flashAddr,
	output logic bufLoad,
	// Core controls.
	output logic cpuHalt,
	output logic rwwBlocked,
	output logic spmIgnored,
	output logic lpmGrant,
	output logic lpmDeny,
	output logic irqSuppress,
	output logic [ADDR_W-1:0] resetVector
);
	import flash_guard_pkg::*;

	localparam logic [ADDR_W:0] NO_READ_WHILE_WRITE_AREA_START = (ADDR_W+1)'((1 << ADDR_W) - NO_READ_WHILE_WRITE_AREA_WORDS);

	flash_area_if #(.ADDR_W(ADDR_W)) areaBus ();

	flash_area_decode #(
		.ADDR_W(ADDR_W),
		.BOOT_MIN_WORDS(BOOT_MIN_WORDS),
		.NO_READ_WHILE_WRITE_AREA_WORDS(NO_READ_WHILE_WRITE_AREA_WORDS)
	) areaDecode (
		.area(areaBus.decoder)
	);

	prog_state_t state_ff;
	spm_cmd_t cmd_ff;
	logic [2:0] windowCnt_ff;
	logic [1:0] appLock_ff;
	logic [1:0] bootLock_ff;
	logic vecInBoot_ff;
	logic rwwBusy_ff;
	logic cpuHalt_ff;
	logic flashStart_ff;
	logic flashErase_ff;
	logic flashWrite_ff;
	logic [ADDR_W-1:0] flashAddr_ff;
	logic bufLoad_ff;
	logic spmIgnored_ff;
	logic lpmGrant_ff;
	logic lpmDeny_ff;
	logic irqSuppress_ff;
	logic [ADDR_W-1:0] resetVector_ff;
	logic hreadyout_ff;
	logic [31:0] hrdata_ff;
	logic wrPend_ff;
	logic [7:0] wrAddr_ff;
	logic addrPhase;
	logic ctrlWrite;
	logic spmFromBoot;
	logic progCmd;
	logic progRefused;
	logic lpmRefused;
	logic [31:0] nxt_hrdata;
	spm_cmd_t nxt_cmd;

	// Address decoder inputs; a store request takes the target path over a load.
	assign areaBus.bootSize = bootSizeFuses;
	assign areaBus.pcAddr = pcAddr;
	assign areaBus.tgtAddr = spmReq ? spmAddr : lpmAddr;

	// Bus handshake terms; the slave never inserts wait states.
	assign addrPhase = hsel && hready && htrans[1];
	assign ctrlWrite = wrPend_ff && (wrAddr_ff == CTRL_OFFSET);
	assign spmFromBoot = spmReq && areaBus.pcInBoot && (state_ff == ST_ARMED);
	assign progCmd = (cmd_ff == CMD_ERASE) || (cmd_ff == CMD_WRITE);
	// Target area versus lock of that area; general lock modes are deliberately not consulted.
	assign progRefused = areaBus.tgtInBoot ? write_blocked(bootLock_ff)
		: write_blocked(appLock_ff);
	assign lpmRefused = (!areaBus.pcInBoot && areaBus.tgtInBoot && read_blocked(bootLock_ff))
		|| (areaBus.pcInBoot && !areaBus.tgtInBoot && read_blocked(appLock_ff))
		|| (areaBus.tgtInRww && rwwBusy_ff);

	// Decode the low five control bits; any other pattern has no effect.
	always_comb begin
		case (hwdata[4:0])
			CMD_PAT_LOAD: nxt_cmd = CMD_LOAD;
			CMD_PAT_ERASE: nxt_cmd = CMD_ERASE;
			CMD_PAT_WRITE: nxt_cmd = CMD_WRITE;
			CMD_PAT_LOCKSET: nxt_cmd = CMD_LOCKSET;
			CMD_PAT_REENABLE: nxt_cmd = CMD_REENABLE;
			default: nxt_cmd = CMD_NONE;
		endcase
	end

	// Command sequencer; while a page is programmed the enable stays set and writes are refused.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_ff <= ST_IDLE;
			cmd_ff <= CMD_NONE;
			windowCnt_ff <= 3'h0;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (ctrlWrite && nxt_cmd != CMD_NONE) begin
						state_ff <= ST_ARMED;
						cmd_ff <= nxt_cmd;
						windowCnt_ff <= 3'(SPM_WINDOW_CYCLES - 1);
					end
				end
				ST_ARMED: begin
					if (spmFromBoot) begin
						if (progCmd && !progRefused) begin
							state_ff <= ST_PROGRAM;
						end else begin
							state_ff <= ST_IDLE;
							cmd_ff <= CMD_NONE;
						end
					end else if (windowCnt_ff == 3'h0) begin
						state_ff <= ST_IDLE;
						cmd_ff <= CMD_NONE;
					end else begin
						windowCnt_ff <= windowCnt_ff - 3'h1;
					end
				end
				ST_PROGRAM: begin
					if (flashDone) begin
						state_ff <= ST_IDLE;
						cmd_ff <= CMD_NONE;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// Flash array strobes; halting depends only on where the target page lies.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			flashStart_ff <= 1'b0;
			flashErase_ff <= 1'b0;
			flashWrite_ff <= 1'b0;
			flashAddr_ff <= '0;
			cpuHalt_ff <= 1'b0;
			bufLoad_ff <= 1'b0;
			spmIgnored_ff <= 1'b0;
		end else begin
			flashStart_ff <= spmFromBoot && progCmd && !progRefused;
			bufLoad_ff <= spmFromBoot && (cmd_ff == CMD_LOAD);
			spmIgnored_ff <= spmReq && !spmFromBoot;
			if (spmFromBoot && progCmd && !progRefused) begin
				flashErase_ff <= cmd_ff == CMD_ERASE;
				flashWrite_ff <= cmd_ff == CMD_WRITE;
				flashAddr_ff <= spmAddr;
				cpuHalt_ff <= !areaBus.tgtInRww;
			end else if (state_ff == ST_PROGRAM && flashDone) begin
				flashErase_ff <= 1'b0;
				flashWrite_ff <= 1'b0;
				cpuHalt_ff <= 1'b0;
			end
		end
	end

	// Busy flag: set on read-while-write programming, cleared by re-enable or buffer load.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			rwwBusy_ff <= 1'b0;
		end else if (spmFromBoot && progCmd && !progRefused && areaBus.tgtInRww) begin
			rwwBusy_ff <= 1'b1;
		end else if (spmFromBoot && (cmd_ff == CMD_REENABLE || cmd_ff == CMD_LOAD)) begin
			rwwBusy_ff <= 1'b0;
		end
	end

	// Lock fields only ever program toward zero; only chip erase or reset returns them to one.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			appLock_ff <= LOCK_RESET;
			bootLock_ff <= LOCK_RESET;
		end else if (chipErase) begin
			appLock_ff <= LOCK_RESET & (progLockWr ? progLockData[1:0] : LOCK_NONE);
			bootLock_ff <= LOCK_RESET & (progLockWr ? progLockData[3:2] : LOCK_NONE);
		end else if (progLockWr) begin
			appLock_ff <= appLock_ff & progLockData[1:0];
			bootLock_ff <= bootLock_ff & progLockData[3:2];
		end else if (spmFromBoot && cmd_ff == CMD_LOCKSET) begin
			appLock_ff <= appLock_ff & spmData[LOCKDATA_APP_LSB +: 2];
			bootLock_ff <= bootLock_ff & spmData[LOCKDATA_BOOT_LSB +: 2];
		end
	end

	// Load checks; a load in the same cycle as a store is neither granted nor denied.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			lpmGrant_ff <= 1'b0;
			lpmDeny_ff <= 1'b0;
		end else begin
			lpmGrant_ff <= lpmReq && !spmReq && !lpmRefused;
			lpmDeny_ff <= lpmReq && !spmReq && lpmRefused;
		end
	end

	// Interrupt suppression and reset vector follow fuses and locks every cycle.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			irqSuppress_ff <= 1'b0;
			resetVector_ff <= '0;
		end else begin
			irqSuppress_ff <= (!areaBus.pcInBoot && vecInBoot_ff && read_blocked(appLock_ff))
				|| (areaBus.pcInBoot && !vecInBoot_ff && read_blocked(bootLock_ff));
			resetVector_ff <= bootResetFuse ? ADDR_W'(APP_RESET_ADDR) : areaBus.bootStart;
		end
	end

	// Config register; fuses are inputs only, so no bus write can reach them.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			vecInBoot_ff <= CONFIG_RESET;
		end else if (wrPend_ff && wrAddr_ff == CONFIG_OFFSET) begin
			vecInBoot_ff <= hwdata[CFG_VEC_BOOT_BIT];
		end
	end

	// Read data for the address being presented, registered into the data phase.
	always_comb begin
		nxt_hrdata = 32'h0;
		if (haddr[7:0] == CTRL_OFFSET) begin
			nxt_hrdata[CTRL_ENABLE_BIT] = state_ff != ST_IDLE;
			nxt_hrdata[CTRL_ERASE_BIT] = cmd_ff == CMD_ERASE;
			nxt_hrdata[CTRL_WRITE_BIT] = cmd_ff == CMD_WRITE;
			nxt_hrdata[CTRL_LOCKSET_BIT] = cmd_ff == CMD_LOCKSET;
			nxt_hrdata[CTRL_REENABLE_BIT] = cmd_ff == CMD_REENABLE;
			nxt_hrdata[CTRL_RWW_BUSY_BIT] = rwwBusy_ff;
		end else if (haddr[7:0] == STATUS_OFFSET) begin
			nxt_hrdata[STAT_BUSY_BIT] = state_ff == ST_PROGRAM;
			nxt_hrdata[STAT_HALT_BIT] = cpuHalt_ff;
			nxt_hrdata[STAT_PC_BOOT_BIT] = areaBus.pcInBoot;
			nxt_hrdata[STAT_APP_LOCK_LSB +: 2] = appLock_ff;
			nxt_hrdata[STAT_BOOT_LOCK_LSB +: 2] = bootLock_ff;
			nxt_hrdata[STAT_BOOT_SIZE_LSB +: 2] = bootSizeFuses;
			nxt_hrdata[STAT_BOOT_RST_BIT] = bootResetFuse;
			nxt_hrdata[STAT_MEM_LOCK_LSB +: 2] = memLockMode;
		end else if (haddr[7:0] == CONFIG_OFFSET) begin
			nxt_hrdata[CFG_VEC_BOOT_BIT] = vecInBoot_ff;
		end
	end

	// AHB-Lite slave: zero wait states, always OKAY, unmapped reads give zero.
	always_ff @(posedge clock) begin
		if (!nrst) begin
			hreadyout_ff <= 1'b1;
			hrdata_ff <= 32'h0;
			wrPend_ff <= 1'b0;
			wrAddr_ff <= 8'h0;
		end else begin
			hreadyout_ff <= 1'b1;
			wrPend_ff <= addrPhase && hwrite && haddr[31:8] == 24'h0;
			wrAddr_ff <= haddr[7:0];
			if (addrPhase && !hwrite) begin
				hrdata_ff <= haddr[31:8] == 24'h0 ? nxt_hrdata : 32'h0;
			end
		end
	end

	assign hreadyout = hreadyout_ff;
	assign hrdata = hrdata_ff;
	assign hresp = 1'b0;
	assign flashStart = flashStart_ff;
	assign flashErase = flashErase_ff;
	assign flashWrite = flashWrite_ff;
	assign flashAddr = flashAddr_ff;
	assign bufLoad = bufLoad_ff;
	assign cpuHalt = cpuHalt_ff;
	assign rwwBlocked = rwwBusy_ff;
	assign spmIgnored = spmIgnored_ff;
	assign lpmGrant = lpmGrant_ff;
	assign lpmDeny = lpmDeny_ff;
	assign irqSuppress = irqSuppress_ff;
	assign resetVector = resetVector_ff;

	// Checks that tie outputs to their causes.
	chk_app_pc_ignored: assert property (@(posedge clock) disable iff (!nrst)
		spmReq && !areaBus.pcInBoot |=> !flashStart_ff && !bufLoad_ff && spmIgnored_ff)
		else $error("store from application area was not ignored");
	chk_start_from_boot: assert property (@(posedge clock) disable iff (!nrst)
		flashStart_ff |-> $past(spmReq && areaBus.pcInBoot) && state_ff == ST_PROGRAM)
		else $error("flash started without a boot-area store");
	chk_rww_keeps_running: assert property (@(posedge clock) disable iff (!nrst)
		flashStart_ff && !cpuHalt_ff |-> rwwBusy_ff)
		else $error("core running while a no-rww page is programmed");
	chk_no_read_while_write_area_halt_held: assert property (@(posedge clock) disable iff (!nrst)
		cpuHalt_ff && !flashDone |=> cpuHalt_ff)
		else $error("core released before programming ended");
	chk_busy_rise_cause: assert property (@(posedge clock) disable iff (!nrst)
		$rose(rwwBusy_ff) |-> flashStart_ff && !cpuHalt_ff)
		else $error("rww busy set without rww programming");
	chk_boot_in_no_read_while_write_area: assert property (@(posedge clock) disable iff (!nrst)
		{1'b0, areaBus.bootStart} >= NO_READ_WHILE_WRITE_AREA_START)
		else $error("boot area reaches into rww area");
	chk_app_lock_write: assert property (@(posedge clock) disable iff (!nrst)
		spmFromBoot && progCmd && !areaBus.tgtInBoot && write_blocked(appLock_ff)
		|=> !flashStart_ff && state_ff == ST_IDLE)
		else $error("store write into locked application area");
	chk_boot_lock_read: assert property (@(posedge clock) disable iff (!nrst)
		lpmReq && !spmReq && !areaBus.pcInBoot && areaBus.tgtInBoot && read_blocked(bootLock_ff)
		|=> lpmDeny_ff && !lpmGrant_ff)
		else $error("application load of locked boot area granted");
	chk_irq_app_mask: assert property (@(posedge clock) disable iff (!nrst)
		!areaBus.pcInBoot && vecInBoot_ff && read_blocked(appLock_ff) |=> irqSuppress_ff)
		else $error("interrupts not suppressed in protected application");
	chk_enable_held: assert property (@(posedge clock) disable iff (!nrst)
		state_ff == ST_PROGRAM && !flashDone |=> state_ff == ST_PROGRAM)
		else $error("enable dropped before programming completed");
	chk_reset_vector: assert property (@(posedge clock) disable iff (!nrst)
		bootResetFuse ##1 bootResetFuse |-> resetVector_ff == ADDR_W'(APP_RESET_ADDR))
		else $error("reset vector not zero with boot reset fuse unprogrammed");
	cov_rww_program: cover property (@(posedge clock) disable iff (!nrst)
		flashStart_ff && rwwBusy_ff ##[1:50] flashDone);
	cov_no_read_while_write_area_program: cover property (@(posedge clock) disable iff (!nrst)
		flashStart_ff && cpuHalt_ff);
	cov_lpm_denied: cover property (@(posedge clock) disable iff (!nrst) lpmDeny_ff);
endmodule : flash_self_program_guard

// File: tb/core_model.sv
// Core model issuing store and load requests, with a flash array answering each start.
`timescale 1ns/1ps
module core_model #(
	parameter int ADDR_W = 13,
	parameter int DONE_CYC = 40
) (
	// Clock.
	input wire logic clock,
	// Core side of the guard.
	output logic [ADDR_W-1:0] pcAddr,
	output logic spmReq,
	output logic [ADDR_W-1:0] spmAddr,
	output logic [7:0] spmData,
	output logic lpmReq,
	output logic [ADDR_W-1:0] lpmAddr,
	input wire logic cpuHalt,
	// Flash array side.
	input wire logic flashStart,
	output logic flashDone
);
	int cnt = 0;

	// Idle values at time zero; the core starts in boot code.
	initial begin
		pcAddr = 13'h1f00;
		{spmReq, lpmReq, flashDone} = '0;
		{spmAddr, lpmAddr, spmData} = '1;
	end

	// The array ends a fixed time after each start; a larger DONE_CYC models a slow array.
	always @(posedge clock) begin
		flashDone <= (cnt == 1);
		if (flashStart === 1'b1) cnt <= DONE_CYC;
		else if (cnt != 0) cnt <= cnt - 1;
	end

	// One store request; a halted core issues nothing, and the lines show garbage after it.
	task automatic store(input logic [ADDR_W-1:0] pc, a, input logic [7:0] d);
		@(posedge clock);
		while (cpuHalt === 1'b1) @(posedge clock);
		pcAddr <= pc;
		spmReq <= 1'b1;
		spmAddr <= a;
		spmData <= d;
		@(posedge clock);
		spmReq <= 1'b0;
		spmAddr <= ~a;
		spmData <= ~d;
		repeat (2) @(posedge clock);
		#1;
	endtask : store

	// One load request; the answer pulses one cycle later.
	task automatic load(input logic [ADDR_W-1:0] pc, a);
		@(posedge clock);
		pcAddr <= pc;
		lpmReq <= 1'b1;
		lpmAddr <= a;
		@(posedge clock);
		lpmReq <= 1'b0;
		lpmAddr <= ~a;
		repeat (2) @(posedge clock);
		#1;
	endtask : load
endmodule : core_model

// File: tb/testbench.sv
// Self-checking testbench for the flash self-programming guard.
`timescale 1ns/1ps
module testbench;
	import flash_guard_pkg::*;
	localparam logic [12:0] APP = 13'h0010, RWWP = 13'h0100, NRWWP = 13'h1900, BOOT = 13'h1f00;
	logic clock, nrst, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, bootSizeFuses, memLockMode;
	logic [2:0] hsize;
	logic [3:0] progLockData;
	logic bootResetFuse, progLockWr, chipErase, flashDone, flashStart, flashErase, flashWrite;
	logic bufLoad, cpuHalt, rwwBlocked, spmIgnored, lpmGrant, lpmDeny, irqSuppress;
	logic spmReq, lpmReq;
	logic [7:0] spmData;
	logic [12:0] pcAddr, spmAddr, lpmAddr, flashAddr, resetVector;
	logic [12:0] own [2] = '{APP, BOOT};
	logic [31:0] clrCmd [2] = '{32'h11, 32'h01};
	int errors, checked, nStart, nIgn, nGrant, nDeny, nLoad;

	// The one slave's ready is the bus ready.
	assign hready = hreadyout;
	flash_self_program_guard i_dut (.*);
	core_model i_core (.*);

	// Free-running 40 MHz clock.
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// Pulses are counted at the edge that shows them, so none is missed between checks.
	always @(posedge clock) begin
		if (flashStart === 1'b1) nStart++;
		if (spmIgnored === 1'b1) nIgn++;
		if (lpmGrant === 1'b1) nGrant++;
		if (lpmDeny === 1'b1) nDeny++;
		if (bufLoad === 1'b1) nLoad++;
	end

	// Compares one value and reports a mismatch at once.
	task automatic check(input string what, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : print_verdict

	// Clears the pulse counters between scenarios.
	task automatic clr();
		{nStart, nIgn, nGrant, nDeny, nLoad} = '0;
	endtask : clr

	// Reset held four cycles with the given fuse levels.
	task automatic doReset(input logic [1:0] sz, input logic rf);
		@(posedge clock);
		nrst <= 1'b0;
		bootSizeFuses <= sz;
		bootResetFuse <= rf;
		repeat (4) @(posedge clock);
		nrst <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
	endtask : doReset

	// One programmer pulse: chip erase, lock programming, or neither.
	task automatic prog(input logic e, w, input logic [3:0] d);
		@(posedge clock);
		chipErase <= e;
		progLockWr <= w;
		progLockData <= d;
		@(posedge clock);
		chipErase <= 1'b0;
		progLockWr <= 1'b0;
	endtask : prog

	// Single word transfer; the master never assumes how soon ready comes.
	task automatic ahb(input logic wr, input logic [31:0] a, d);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge clock); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wr ? d : 32'h0;
		do @(posedge clock); while (hready !== 1'b1);
		rd = hrdata;
		#1;
	endtask : ahb

	// Waits for the array to finish and the guard to return to idle.
	task automatic waitDone();
		do @(posedge clock); while (flashErase !== 1'b0 || flashWrite !== 1'b0);
		repeat (2) @(posedge clock);
		#1;
	endtask : waitDone

	// Hang guard, far beyond the fewer than one thousand cycles the sequence needs.
	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		print_verdict();
	end

	// Main sequence; the general lock mode is held at its strictest, which must change nothing.
	initial begin
		{nrst, hsel, hwrite, progLockWr, chipErase, haddr, hwdata, htrans, progLockData} = '0;
		{hsize, memLockMode, bootSizeFuses, bootResetFuse} = {3'h2, 2'h0, 2'h3, 1'b1};
		for (int s = 0; s < 4; s++) begin
			doReset(s[1:0], 1'b0);
			check("vector", 32'(resetVector), 32'(8192 - (256 << (3 - s))));
		end
		doReset(2'h3, 1'b1);
		check("vector", 32'(resetVector), 32'h0);
		ahb(1'b1, 32'h4, 32'h0);
		ahb(1'b0, 32'h4, 32'h0);
		check("status", rd, 32'h7f4);
		check("bus", 32'({hreadyout, hresp}), 32'h2);
		ahb(1'b1, 32'hc, 32'hffff_ffff);
		ahb(1'b0, 32'hc, 32'h0);
		check("unmapped", rd, 32'h0);
		ahb(1'b0, 32'h100, 32'h0);
		check("unmapped", rd, 32'h0);
		// Read-while-write erase, freed once by re-enable and once by a buffer load.
		foreach (clrCmd[i]) begin
			ahb(1'b1, 32'h0, 32'h3);
			clr();
			i_core.store(BOOT, RWWP, 8'h0);
			check("start", nStart, 1);
			check("busy", rwwBlocked, 1);
			check("halt", cpuHalt, 0);
			check("target", 32'(flashAddr), 32'(RWWP));
			check("erase", flashErase, 1);
			i_core.load(BOOT, NRWWP);
			check("grant", nGrant, 1);
			ahb(1'b0, 32'h0, 32'h0);
			check("ctrl", rd & 32'h41, 32'h41);
			ahb(1'b1, 32'h0, 32'h11);
			i_core.store(BOOT, 13'h0, 8'h0);
			check("busy", rwwBlocked, 1);
			waitDone();
			ahb(1'b1, 32'h0, clrCmd[i]);
			i_core.store(BOOT, 13'h0, 8'h0);
			check("busy", rwwBlocked, 0);
			check("bufload", nLoad, i);
		end
		// A page outside the read-while-write area stalls the core until written.
		ahb(1'b1, 32'h0, 32'h5);
		i_core.store(BOOT, NRWWP, 8'h0);
		check("halt", cpuHalt, 1);
		check("write", flashWrite, 1);
		check("busy", rwwBlocked, 0);
		waitDone();
		check("halt", cpuHalt, 0);
		// A store from application code is ignored even when armed.
		ahb(1'b1, 32'h0, 32'h3);
		clr();
		i_core.store(APP, RWWP, 8'h0);
		check("ignored", nIgn, 1);
		check("start", nStart, 0);
		repeat (6) @(posedge clock);
		// Every pattern of each lock field, the other left unprogrammed, against a cross-area load and a store erase.
		for (int k = 0; k < 2; k++) begin
			for (int p = 0; p < 4; p++) begin
				prog(1'b1, 1'b0, 4'h0);
				prog(1'b0, 1'b1, k ? {p[1:0], 2'h3} : {2'h3, p[1:0]});
				ahb(1'b1, 32'h8, 32'(1 - k));
				clr();
				i_core.load(own[1 - k], own[k]);
				check("deny", nDeny, 32'(!p[1]));
				i_core.load(own[k], own[k]);
				check("irq", irqSuppress, 32'(!p[1]));
				ahb(1'b1, 32'h0, 32'h3);
				i_core.store(BOOT, own[k], 8'h0);
				check("start", nStart, 32'(p[0]));
				waitDone();
				ahb(1'b1, 32'h0, 32'h11);
				i_core.store(BOOT, 13'h0, 8'h0);
			end
		end
		// Software can only program lock bits; a chip erase returns them to ones.
		ahb(1'b1, 32'h0, 32'h9);
		i_core.store(BOOT, 13'h0, 8'hdb);
		ahb(1'b1, 32'h0, 32'h9);
		i_core.store(BOOT, 13'h0, 8'hff);
		ahb(1'b0, 32'h4, 32'h0);
		check("locks", 32'(rd[7:4]), 32'h6);
		prog(1'b1, 1'b0, 4'h0);
		ahb(1'b0, 32'h4, 32'h0);
		check("locks", 32'(rd[7:4]), 32'hf);
		print_verdict();
	end
endmodule : testbench
